// File: src/tgc_defines.svh
`ifndef TGC_DEFINES_SVH
`define TGC_DEFINES_SVH

// register byte offsets on the apb bus
`define TGC_OFF_GATE_CTRL 12'h000
`define TGC_OFF_TIMER_CTRL 12'h004
`define TGC_OFF_STATUS 12'h008

// gate control field positions
`define TGC_BIT_GATE_ENABLE 7
`define TGC_BIT_GATE_POLARITY 6
`define TGC_BIT_TOGGLE_MODE 5
`define TGC_BIT_SINGLE_PULSE_MODE 4
`define TGC_BIT_SP_STATUS 3
`define TGC_BIT_GATE_STATE 2
`define TGC_BIT_SRC_HI 1
`define TGC_BIT_SRC_LO 0

// timer control field position
`define TGC_BIT_TIMER_ON 0

// gate source codes
`define TGC_SRC_PIN 2'h0
`define TGC_SRC_TMR0 2'h1
`define TGC_SRC_CMP1 2'h2
`define TGC_SRC_CMP2 2'h3

// reset values
`define TGC_RST_BYTE 8'h00

`endif

// File: src/tgc_pkg.sv
package tgc_pkg;
    // gate control register image
    typedef struct packed {
        logic gate_enable;
        logic gate_polarity;
        logic gate_toggle_mode;
        logic gate_single_pulse_mode;
        logic single_pulse_status;
        logic gate_current_state;
        logic [1:0] gate_source_select;
    } tgc_gate_ctrl_s;

    // gate source inputs from other blocks and the pin
    typedef struct packed {
        logic gate_pin;
        logic tmr0_overflow;
        logic comparator_one_sync_out;
        logic comparator_two_sync_out;
    } tgc_sources_s;

    // single-pulse acquisition phases
    typedef enum logic [1:0] {
        SP_IDLE,
        SP_WAIT_EDGE,
        SP_ACQUIRE
    } tgc_sp_e;
endpackage : tgc_pkg

// File: src/tgc_gate_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tgc_defines.svh"

// Summary of operation
// - gate enable with timer on gates counting
// - gate enable clear counts every tick
// - polarity one active high, zero low
// - toggle mode clear also clears flip-flop
// - toggle flip-flop flips on polarised source rising edge
// - single-pulse bit places gate under control
// - status armed reads one, hardware clears
// - status zero when done or unstarted
// - gate state bit independent of enable
// - two-bit select picks pin, tmr0, comparators
module tgc_gate_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // gate sources, asynchronous to pclk
    input wire tgc_pkg::tgc_sources_s sources,
    // timer tick from the prescaler, same domain
    input wire logic timer_tick,
    // counter increment request
    output logic count_en
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic gate_enable_q, gate_polarity_q, toggle_mode_q, sp_mode_q;
    logic sp_status_q, timer_on_q;
    logic [1:0] src_sel_q;
    logic [3:0] sync1_q, sync2_q;
    logic gate_raw_q, toggle_ff_q, sp_gate, gate_state_q;
    tgc_pkg::tgc_sp_e sp_state_q;
    logic gate_src, gate_pol, gate_eff, src_rise;
    logic wr_acc, rd_acc;

    // picks one of four sources by select code
    function automatic logic pick_src(input logic [3:0] s, input logic [1:0] sel);
        unique case (sel)
            `TGC_SRC_PIN: pick_src = s[3];
            `TGC_SRC_TMR0: pick_src = s[2];
            `TGC_SRC_CMP1: pick_src = s[1];
            `TGC_SRC_CMP2: pick_src = s[0];
        endcase
    endfunction : pick_src

    // one apb access per two cycles, no wait states
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers; first stage read only by second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= sources;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source mux then polarity
    assign gate_src = pick_src(sync2_q, src_sel_q);
    assign gate_pol = gate_polarity_q ? gate_src : !gate_src;
    assign src_rise = gate_pol && !gate_raw_q;

    // previous polarised level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_raw_q <= 1'b0;
        end else begin
            gate_raw_q <= gate_pol;
        end
    end

    // toggle flip-flop, held clear while mode is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_ff_q <= 1'b0;
        end else if (!toggle_mode_q) begin
            toggle_ff_q <= 1'b0;
        end else if (src_rise) begin
            toggle_ff_q <= !toggle_ff_q;
        end
    end

    // gate after toggle stage
    logic gate_tg;
    assign gate_tg = toggle_mode_q ? toggle_ff_q : gate_pol;
    logic tg_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tg_prev_q <= 1'b0;
        end else begin
            tg_prev_q <= gate_tg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // single-pulse: arm, wait for rising gate, pass one pulse, done on fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_state_q <= tgc_pkg::SP_IDLE;
        end else if (!sp_mode_q) begin
            sp_state_q <= tgc_pkg::SP_IDLE;
        end else begin
            unique case (sp_state_q)
                tgc_pkg::SP_IDLE:
                    if (sp_status_q) sp_state_q <= tgc_pkg::SP_WAIT_EDGE;
                tgc_pkg::SP_WAIT_EDGE:
                    if (gate_tg && !tg_prev_q) sp_state_q <= tgc_pkg::SP_ACQUIRE;
                tgc_pkg::SP_ACQUIRE:
                    if (!gate_tg) sp_state_q <= tgc_pkg::SP_IDLE;
                default: sp_state_q <= tgc_pkg::SP_IDLE;
            endcase
        end
    end

    // gate passed by single-pulse logic
    always_comb begin
        sp_gate = (sp_state_q == tgc_pkg::SP_ACQUIRE) && gate_tg;
    end
    assign gate_eff = sp_mode_q ? sp_gate : gate_tg;

    // live gate state, not affected by gate enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_state_q <= 1'b0;
        end else begin
            gate_state_q <= gate_eff;
        end
    end

    // counter increment, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_en <= 1'b0;
        end else if (!timer_on_q) begin
            count_en <= 1'b0;
        end else if (!gate_enable_q) begin
            count_en <= timer_tick;
        end else begin
            count_en <= timer_tick && gate_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register writes; zero at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_enable_q <= 1'b0;
            gate_polarity_q <= 1'b0;
            toggle_mode_q <= 1'b0;
            sp_mode_q <= 1'b0;
            src_sel_q <= 2'h0;
            timer_on_q <= 1'b0;
        end else if (wr_acc && paddr == `TGC_OFF_GATE_CTRL) begin
            gate_enable_q <= pwdata[`TGC_BIT_GATE_ENABLE];
            gate_polarity_q <= pwdata[`TGC_BIT_GATE_POLARITY];
            toggle_mode_q <= pwdata[`TGC_BIT_TOGGLE_MODE];
            sp_mode_q <= pwdata[`TGC_BIT_SINGLE_PULSE_MODE];
            src_sel_q <= pwdata[`TGC_BIT_SRC_HI:`TGC_BIT_SRC_LO];
        end else if (wr_acc && paddr == `TGC_OFF_TIMER_CTRL) begin
            timer_on_q <= pwdata[`TGC_BIT_TIMER_ON];
        end
    end

    // status: software sets, hardware clears at completion or mode off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_status_q <= 1'b0;
        end else if (!sp_mode_q) begin
            sp_status_q <= 1'b0;
        end else if (sp_state_q == tgc_pkg::SP_ACQUIRE && !gate_tg) begin
            sp_status_q <= 1'b0;
        end else if (wr_acc && paddr == `TGC_OFF_GATE_CTRL
                     && pwdata[`TGC_BIT_SP_STATUS]) begin
            sp_status_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in setup phase; pready always high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_acc) begin
            unique case (paddr)
                `TGC_OFF_GATE_CTRL: prdata <= {24'h0, gate_enable_q, gate_polarity_q,
                    toggle_mode_q, sp_mode_q, sp_status_q, gate_state_q, src_sel_q};
                `TGC_OFF_TIMER_CTRL: prdata <= {31'h0, timer_on_q};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // constant ready, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            pslverr <= psel && !penable && paddr != `TGC_OFF_GATE_CTRL
                       && paddr != `TGC_OFF_TIMER_CTRL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_off_no_count;
        @(posedge pclk) disable iff (!presetn) !timer_on_q |=> !count_en;
    endproperty
    a_off_no_count: assert property (p_off_no_count)
        else $error("counted while off");

    // no tick, no increment, whatever the gate does
    property p_no_tick;
        @(posedge pclk) disable iff (!presetn) !timer_tick |=> !count_en;
    endproperty
    a_no_tick: assert property (p_no_tick)
        else $error("counted without a tick");

    property p_free_run;
        @(posedge pclk) disable iff (!presetn)
            timer_on_q && !gate_enable_q && timer_tick |=> count_en;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("missed ungated tick");

    property p_gated;
        @(posedge pclk) disable iff (!presetn)
            timer_on_q && gate_enable_q && !gate_eff |=> !count_en;
    endproperty
    a_gated: assert property (p_gated)
        else $error("counted with gate closed");

    // plain gate opens when the selected level matches the polarity
    property p_polarity;
        @(posedge pclk) disable iff (!presetn)
            timer_on_q && gate_enable_q && !toggle_mode_q && !sp_mode_q && timer_tick
            && gate_src == gate_polarity_q |=> count_en;
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("missed tick with gate open");

    // mux against the synchronised source bits, pin in the top bit
    property p_src_sel;
        @(posedge pclk) disable iff (!presetn)
            gate_src == (src_sel_q == `TGC_SRC_PIN ? sync2_q[3]
                : src_sel_q == `TGC_SRC_TMR0 ? sync2_q[2]
                : src_sel_q == `TGC_SRC_CMP1 ? sync2_q[1] : sync2_q[0]);
    endproperty
    a_src_sel: assert property (p_src_sel)
        else $error("wrong gate source selected");

    property p_toggle_clear;
        @(posedge pclk) disable iff (!presetn) !toggle_mode_q |=> !toggle_ff_q;
    endproperty
    a_toggle_clear: assert property (p_toggle_clear)
        else $error("toggle ff not cleared");

    property p_toggle_flip;
        @(posedge pclk) disable iff (!presetn)
            toggle_mode_q && src_rise |=> toggle_ff_q != $past(toggle_ff_q);
    endproperty
    a_toggle_flip: assert property (p_toggle_flip)
        else $error("toggle ff did not flip");

    property p_sp_off;
        @(posedge pclk) disable iff (!presetn) !sp_mode_q |=> sp_state_q == tgc_pkg::SP_IDLE;
    endproperty
    a_sp_off: assert property (p_sp_off)
        else $error("single pulse active while off");

    // armed or finished single pulse keeps the counter still
    property p_sp_hold;
        @(posedge pclk) disable iff (!presetn)
            timer_on_q && gate_enable_q && sp_mode_q && sp_state_q != tgc_pkg::SP_ACQUIRE
            |=> !count_en;
    endproperty
    a_sp_hold: assert property (p_sp_hold)
        else $error("counted outside the single pulse");

    // software arm lands unless the hardware clear wins
    sequence s_arm;
        wr_acc && paddr == `TGC_OFF_GATE_CTRL && pwdata[`TGC_BIT_SP_STATUS] && sp_mode_q
            && !(sp_state_q == tgc_pkg::SP_ACQUIRE && !gate_tg);
    endsequence
    property p_sp_arm;
        @(posedge pclk) disable iff (!presetn) s_arm |=> sp_status_q;
    endproperty
    a_sp_arm: assert property (p_sp_arm)
        else $error("status not armed by write");

    sequence s_acq_end;
        sp_state_q == tgc_pkg::SP_ACQUIRE && !gate_tg && sp_mode_q;
    endsequence
    property p_sp_done;
        @(posedge pclk) disable iff (!presetn) s_acq_end |=> !sp_status_q;
    endproperty
    a_sp_done: assert property (p_sp_done)
        else $error("status not cleared at done");

    property p_sp_clear;
        @(posedge pclk) disable iff (!presetn) !sp_mode_q |=> !sp_status_q;
    endproperty
    a_sp_clear: assert property (p_sp_clear)
        else $error("status set with mode off");

    // reset edge left out: the flop is held at zero while gate_eff is live
    property p_gate_state;
        @(posedge pclk) disable iff (!presetn) presetn |=> gate_state_q == $past(gate_eff);
    endproperty
    a_gate_state: assert property (p_gate_state)
        else $error("gate state bit stale");

endmodule : tgc_gate_ctrl

`default_nettype wire

// File: verif/tgc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side levels: pin, overflow, comparators; slow adds a cycle of lag
module tgc_src_model (
    // clock
    input wire logic pclk,
    // bench command
    input wire logic slow,
    input wire tgc_pkg::tgc_sources_s want,
    // levels seen by the gate block
    output tgc_pkg::tgc_sources_s sources
);
    tgc_pkg::tgc_sources_s want_q;
    // levels move on the rising edge; the design synchronises them anyway
    always @(posedge pclk) begin
        want_q <= want;
        sources <= slow ? want_q : want;
    end
endmodule : tgc_src_model
`default_nettype wire

// File: verif/tgc_gate_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tgc_defines.svh"
`define TGC_CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tgc_gate_ctrl_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_tick, count_en;
    logic slow, e, ce, gs;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    tgc_pkg::tgc_sources_s want, sources;
    int fails, checks_done, cyc;
    ////////////////////////////////////////////////////////////////////////////////
    tgc_gate_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sources(sources), .timer_tick(timer_tick), .count_en(count_en));
    tgc_src_model src (.pclk(pclk), .slow(slow), .want(want), .sources(sources));
    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // hang guard, far above the roughly five hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("fails=%0d checks_done=%0d", fails, checks_done);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cfg(input logic [7:0] g, input logic on);
        apb(1'b1, `TGC_OFF_GATE_CTRL, g);
        apb(1'b1, `TGC_OFF_TIMER_CTRL, {7'h00, on});
    endtask : cfg
    // let levels pass the synchronizer, read gate state, then send one tick
    task automatic look;
        repeat (5) @(posedge pclk);
        apb(1'b0, `TGC_OFF_GATE_CTRL, 8'h00);
        gs = rd[`TGC_BIT_GATE_STATE];
        @(posedge pclk);
        timer_tick <= 1'b1;
        @(posedge pclk);
        timer_tick <= 1'b0;
        #1 ce = count_en;
    endtask : look
    task automatic pulse;
        want.gate_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        want.gate_pin <= 1'b0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(1'b0, `TGC_OFF_GATE_CTRL, 8'h00);
        `TGC_CHK({rd[7:3], 1'b0, rd[1:0]}, `TGC_RST_BYTE)
        `TGC_CHK(rd[`TGC_BIT_GATE_STATE], 1'b1)
        apb(1'b0, `TGC_OFF_TIMER_CTRL, 8'h00);
        `TGC_CHK(rd[7:0], `TGC_RST_BYTE)
        apb(1'b1, `TGC_OFF_STATUS, 8'hff);
        `TGC_CHK(e, 1'b1)
        apb(1'b0, `TGC_OFF_STATUS, 8'h00);
        `TGC_CHK(rd, 32'h00000000)
    endtask : t_reset
    task automatic t_enable;
        cfg(8'h80, 1'b0);
        look();
        `TGC_CHK(ce, 1'b0)
        cfg(8'hc0, 1'b1);
        look();
        `TGC_CHK(ce, 1'b0)
        `TGC_CHK(gs, 1'b0)
        cfg(8'h40, 1'b1);
        look();
        `TGC_CHK(ce, 1'b1)
        want.gate_pin <= 1'b1;
        look();
        `TGC_CHK(gs, 1'b1)
    endtask : t_enable
    // every select code and both polarities; unselected sources sit opposite
    task automatic t_select;
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 4; v++) begin
                slow <= v[0];
                want <= v[0] ? (4'h8 >> s) : ~(4'h8 >> s);
                cfg({1'b1, v[1], 4'h0, s[1:0]}, 1'b1);
                look();
                `TGC_CHK(ce, v[0] == v[1])
            end
        end
    endtask : t_select
    task automatic t_toggle;
        want <= 4'h0;
        cfg(8'he0, 1'b1);
        pulse();
        look();
        `TGC_CHK(ce, 1'b1)
        pulse();
        look();
        `TGC_CHK(ce, 1'b0)
        pulse();
        cfg(8'hc0, 1'b1);
        cfg(8'he0, 1'b1);
        look();
        `TGC_CHK(gs, 1'b0)
    endtask : t_toggle
    // software arms only after single-pulse mode is on
    task automatic t_single;
        want <= 4'h0;
        cfg(8'hd0, 1'b1);
        apb(1'b0, `TGC_OFF_GATE_CTRL, 8'h00);
        `TGC_CHK(rd[`TGC_BIT_SP_STATUS], 1'b0)
        apb(1'b1, `TGC_OFF_GATE_CTRL, 8'hd8);
        look();
        `TGC_CHK(rd[`TGC_BIT_SP_STATUS], 1'b1)
        `TGC_CHK(ce, 1'b0)
        want.gate_pin <= 1'b1;
        look();
        `TGC_CHK(ce, 1'b1)
        want.gate_pin <= 1'b0;
        look();
        `TGC_CHK(rd[`TGC_BIT_SP_STATUS], 1'b0)
        want.gate_pin <= 1'b1;
        look();
        `TGC_CHK(ce, 1'b0)
        cfg(8'hc0, 1'b1);
        look();
        `TGC_CHK(ce, 1'b1)
    endtask : t_single
    ////////////////////////////////////////////////////////////////////////////////
    // reset for 12 cycles, then the scenarios in turn
    initial begin
        {presetn, psel, penable, pwrite, timer_tick, slow} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        want = 4'h0;
        {fails, checks_done, cyc} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_enable();
        t_select();
        t_toggle();
        t_single();
        finish_test();
    end
endmodule : tgc_gate_ctrl_tb_top
`default_nettype wire
